// *** inc/ntc_pkg.sv ***
/*
 * constants shared by the network time counter: widths, reset values,
 * the one-second limit and the 8 kHz half period.
 * assumes a single reference clock and software-free static inputs.
 */
package ntc_pkg;
	// -----------------------------------------------------------------
	// field widths
	// -----------------------------------------------------------------
	localparam int NS_W = 32;
	localparam int SEC_W = 48;
	localparam int FRAC_W = 20;
	localparam int INC_W = 26;
	localparam int INC_INT_W = 6;
	// -----------------------------------------------------------------
	// values
	// -----------------------------------------------------------------
	localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3B9A_CA00;
	localparam logic [NS_W-1:0] NS_RST = 32'h0000_0000;
	localparam logic [SEC_W-1:0] SEC_RST = 48'h0000_0000_0000;
	localparam logic [FRAC_W-1:0] FRAC_RST = 20'h00000;
	localparam logic [INC_W-1:0] INC_NOMINAL_8NS = 26'h080_0000;
	localparam logic [NS_W-1:0] MAX_STEP_NS = 32'h0000_0040;
	// 8 kHz: 125000 ns period, toggles every 62500 ns of synced time
	localparam logic [NS_W-1:0] HALF_8K_NS = 32'h0000_F424;
	localparam logic [NS_W-1:0] PERIOD_8K_NS = 32'h0001_E848;
endpackage : ntc_pkg

// *** rtl/sec_ns_adder.sv ***
/*
 * adds a nanoseconds offset to a nanoseconds value and folds
 * the result back under one second, giving the carry into seconds.
 * assumes both inputs are already below one second.
 */
`timescale 1ns/1ps
module sec_ns_adder
	import ntc_pkg::*;
(
	input wire logic [NS_W-1:0] ns_a,
	input wire logic [NS_W-1:0] ns_b,
	output logic [NS_W-1:0] ns_sum,
	output logic carry
);
	logic [NS_W:0] raw;
	always_comb begin
		raw = {1'b0, ns_a} + {1'b0, ns_b};
		if (raw >= {1'b0, NS_PER_SEC}) begin
			ns_sum = NS_W'(raw - {1'b0, NS_PER_SEC});
			carry = 1'b1;
		end else begin
			ns_sum = raw[NS_W-1:0];
			carry = 1'b0;
		end
	end
endmodule : sec_ns_adder

// *** rtl/network_time_counter.sv ***
/*
 * network time counter: free-running controlled-frequency time with a
 * 20-bit fraction, plus software offsets forming the synchronized time,
 * and an 8 kHz clock derived from the synchronized nanoseconds.
 * assumes the increment and offsets are static inputs from the
 * surrounding configuration logic on the same reference clock.
 */
// Notes on behaviour
// - nanoseconds count 32 bits, wraps at one second
// - 48-bit seconds advance on nanosecond rollover
// - increment unit is 2^-20 nanosecond
// - 20-bit fraction concatenated below nanoseconds
// - everything runs on the one reference clock
// - 26-bit increment: 20 fraction, 6 nanosecond bits
// - increment 800000 hex gives 8 ns per cycle
// - free-running time clears on reset, adds increment
// - per-cycle step at most 64 ns
// - synced nanoseconds equal free time plus offset
// - seconds bump at synced rollover, offset steps them
// - offsets allow arbitrary large time steps
// - 8 kHz output follows synchronized time
// - timestamps take free-running nanoseconds
`timescale 1ns/1ps
module network_time_counter
	import ntc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [INC_W-1:0] increment,
	input wire logic [SEC_W-1:0] sec_offset,
	input wire logic [NS_W-1:0] ns_offset,
	output logic [NS_W-1:0] free_ns,
	output logic [NS_W-1:0] synced_ns,
	output logic [SEC_W-1:0] synced_sec,
	output logic synced_8khz_out
);
	// -----------------------------------------------------------------
	// controlled-frequency time
	// -----------------------------------------------------------------
	logic [FRAC_W-1:0] frac_q;
	logic [NS_W-1:0] free_ns_q;
	logic [SEC_W-1:0] free_sec_q;
	logic [NS_W+FRAC_W:0] acc_sum;
	logic [NS_W-1:0] acc_ns;
	logic [NS_W-1:0] free_ns_d;
	logic free_carry;

	// integer bits of the increment land on nanosecond bits [5:0]
	always_comb begin
		acc_sum = {1'b0, free_ns_q, frac_q} +
			(NS_W+FRAC_W+1)'(increment);
		acc_ns = acc_sum[NS_W+FRAC_W-1:FRAC_W];
	end

	// a step never exceeds 64 ns so one subtraction always suffices
	sec_ns_adder u_free_fold (
		.ns_a(acc_ns),
		.ns_b(NS_RST),
		.ns_sum(free_ns_d),
		.carry(free_carry)
	);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			frac_q <= FRAC_RST;
			free_ns_q <= NS_RST;
		end else begin
			frac_q <= acc_sum[FRAC_W-1:0];
			free_ns_q <= free_ns_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			free_sec_q <= SEC_RST;
		end else if (free_carry) begin
			free_sec_q <= free_sec_q + 48'h0000_0000_0001;
		end
	end

	// -----------------------------------------------------------------
	// synchronized time
	// -----------------------------------------------------------------
	logic [NS_W-1:0] sync_ns_d;
	logic sync_carry;
	logic [NS_W-1:0] synced_ns_q;
	logic [SEC_W-1:0] synced_sec_q;
	logic [NS_W-1:0] free_ns_q_out;

	// offset expected below one second; fold covers the sum
	sec_ns_adder u_sync_add (
		.ns_a(free_ns_d),
		.ns_b(ns_offset),
		.ns_sum(sync_ns_d),
		.carry(sync_carry)
	);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			synced_ns_q <= NS_RST;
			synced_sec_q <= SEC_RST;
		end else begin
			synced_ns_q <= sync_ns_d;
			// seconds formed from free seconds, offset, and both carries
			synced_sec_q <= free_sec_q + sec_offset +
				{47'h0, free_carry} + {47'h0, sync_carry};
		end
	end

	// timestamp source: free-running, never the offset-stepped time
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			free_ns_q_out <= NS_RST;
		end else begin
			free_ns_q_out <= free_ns_d;
		end
	end

	// -----------------------------------------------------------------
	// 8 kHz clock
	// -----------------------------------------------------------------
	// a level compare on the synced phase, not a cycle divider, so it
	// follows offset steps and never drifts from network time
	function automatic logic phase_high(input logic [NS_W-1:0] ns);
		logic [NS_W-1:0] r;
		r = ns % PERIOD_8K_NS;
		return r >= HALF_8K_NS;
	endfunction : phase_high

	logic clk8_q;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			clk8_q <= 1'b0;
		end else begin
			clk8_q <= phase_high(sync_ns_d);
		end
	end

	assign free_ns = free_ns_q_out;
	assign synced_ns = synced_ns_q;
	assign synced_sec = synced_sec_q;
	assign synced_8khz_out = clk8_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_ns_below_sec: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		synced_ns_q < NS_PER_SEC && free_ns_q < NS_PER_SEC)
		else $error("nanoseconds reached one second");
	a_free_reset_zero: assert property (
		@(posedge ref_clk)
		!rstn |=> free_ns_q == NS_RST && frac_q == FRAC_RST)
		else $error("free time not cleared by reset");
	a_step_matches_inc: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		rstn && $past(rstn) && !$past(free_carry) |->
		{free_ns_q, frac_q} == $past({free_ns_q, frac_q}) +
		52'($past(increment)))
		else $error("accumulator step differs from increment");
	a_nominal_eight_ns: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		increment == INC_NOMINAL_8NS && frac_q == FRAC_RST &&
		free_ns_q < NS_PER_SEC - 32'h0000_0010 |=>
		free_ns_q == $past(free_ns_q) + 32'h0000_0008)
		else $error("nominal increment not 8 ns");
	a_step_max_64: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		!free_carry |-> acc_ns - free_ns_q <= MAX_STEP_NS)
		else $error("step above 64 ns");
	a_sync_is_sum: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn) |-> synced_ns_q ==
		32'((64'(free_ns_q_out) + 64'($past(ns_offset))) %
		64'(NS_PER_SEC)))
		else $error("synced ns not free plus offset");
	// free seconds need some 15 million cycles even at the largest step,
	// so short runs only reach the synced rollover
	a_sec_wrap_carry: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		free_carry |=> free_sec_q == $past(free_sec_q) + 48'h1)
		else $error("seconds missed rollover");
	a_fold_carry: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		sync_carry |-> {1'b0, free_ns_d} + {1'b0, ns_offset} ==
		{1'b0, sync_ns_d} + {1'b0, NS_PER_SEC})
		else $error("carry fold wrong");
	a_stamp_free: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		free_ns == free_ns_q)
		else $error("timestamp source not free time");
	a_clk8_phase: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn) |-> clk8_q == (synced_ns_q % PERIOD_8K_NS >=
		HALF_8K_NS))
		else $error("8 kHz phase wrong");
	a_sec_hold: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		!free_carry |=> free_sec_q == $past(free_sec_q))
		else $error("seconds moved without rollover");
	a_sync_sec_sum: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn) |-> synced_sec_q == free_sec_q +
		$past(sec_offset) + 48'($past(sync_carry)))
		else $error("synced seconds not free plus offset");
	a_stamp_smooth: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn) && !$past(free_carry) |->
		free_ns - $past(free_ns) <= MAX_STEP_NS)
		else $error("timestamp source stepped");
	a_synced_reset_zero: assert property (
		@(posedge ref_clk)
		!rstn |=> synced_ns_q == NS_RST && synced_sec_q == SEC_RST &&
		!clk8_q && free_ns == NS_RST)
		else $error("outputs not cleared by reset");

	// -----------------------------------------------------------------
	// coverage
	// -----------------------------------------------------------------
	c_free_rollover: cover property (@(posedge ref_clk) free_carry);
	c_sync_rollover: cover property (@(posedge ref_clk) sync_carry);
	c_clk8_rise: cover property (@(posedge ref_clk) $rose(clk8_q));
	c_clk8_fall: cover property (@(posedge ref_clk) $fell(clk8_q));
	c_sec_wrap: cover property (@(posedge ref_clk)
		sync_carry && synced_sec_q == {SEC_W{1'b1}});
endmodule : network_time_counter

// *** tb/network_time_counter_tb.sv ***
/*
 * self-checking bench for the network time counter.
 * assumes registered outputs one cycle after each sampled edge.
 */
`timescale 1ns/1ps
module network_time_counter_tb
	import ntc_pkg::*;
;
	// ---------------------------------------------------------------
	// clock, reset, design
	// ---------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [INC_W-1:0] increment = '0;
	logic [SEC_W-1:0] sec_offset = '0;
	logic [NS_W-1:0] ns_offset = '0;
	logic [NS_W-1:0] free_ns;
	logic [NS_W-1:0] synced_ns;
	logic [SEC_W-1:0] synced_sec;
	logic synced_8khz_out;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #2.5 ref_clk = ~ref_clk;
	network_time_counter network_time_counter_i (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.increment(increment),
		.sec_offset(sec_offset),
		.ns_offset(ns_offset),
		.free_ns(free_ns),
		.synced_ns(synced_ns),
		.synced_sec(synced_sec),
		.synced_8khz_out(synced_8khz_out)
	);
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task complete_run;
		$display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// reset held 3 cycles; first edge after release adds increment
	task restart(input logic [25:0] inc, input logic [47:0] so,
			input logic [31:0] no);
		@(posedge ref_clk);
		rstn <= 1'b0;
		increment <= inc;
		sec_offset <= so;
		ns_offset <= no;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
	endtask : restart
	task run(input int k);
		repeat (k) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : run
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task nominal_rate;
		restart(INC_NOMINAL_8NS, 48'h0000_0000_0007, 32'h0000_0064);
		@(negedge ref_clk);
		check(free_ns, 64'h0);
		check(synced_sec, 64'h0);
		run(5);
		check(free_ns, 64'h28);
		check(synced_ns, 64'h8C);
		check(synced_sec, 64'h7);
	endtask : nominal_rate
	task fraction_rate;
		restart(26'h004_0000, 48'h0, 32'h0);
		run(3);
		check(free_ns, 64'h0);
		run(1);
		check(free_ns, 64'h1);
		restart(26'h3FF_FFFF, 48'h0, 32'h0);
		run(1);
		check(free_ns, 64'h3F);
		run(1);
		check(free_ns, 64'h7F);
	endtask : fraction_rate
	// saturated seconds offset wraps on the carry out of nanoseconds
	task second_rollover;
		restart(INC_NOMINAL_8NS, 48'hFFFF_FFFF_FFFF, 32'h3B9A_C9F0);
		run(1);
		check(synced_ns, 64'h3B9A_C9F8);
		check(synced_sec, 64'hFFFF_FFFF_FFFF);
		run(1);
		check(synced_ns, 64'h0);
		check(synced_sec, 64'h0);
		check(free_ns, 64'h10);
	endtask : second_rollover
	task khz_output;
		restart(INC_NOMINAL_8NS, 48'h0, 32'h0000_F414);
		run(1);
		check(synced_8khz_out, 64'h0);
		run(1);
		check(synced_8khz_out, 64'h1);
		@(posedge ref_clk);
		ns_offset <= 32'h0;
		run(1);
		check(synced_ns, 64'h20);
		check(free_ns, 64'h20);
		check(synced_8khz_out, 64'h0);
	endtask : khz_output
	// ---------------------------------------------------------------
	// sequence and hang guard
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		nominal_rate();
		fraction_rate();
		second_rollover();
		khz_output();
		complete_run();
	end
endmodule : network_time_counter_tb
